// ===== core/drive_cw_map.svh
`ifndef DRIVE_CW_MAP_SVH
`define DRIVE_CW_MAP_SVH

// control word bit positions
`define CW_ON        0
`define CW_COAST     1
`define CW_QUICK     2
`define CW_ENABLE    3
`define CW_RAMP      5
`define CW_SETP      6
`define CW_ACK       7
`define CW_PLC       10
`define CW_TORQUE    11
`define CW_DIR       12
`define CW_HOME      13

// status word bit positions
`define SW_READY     0
`define SW_SWON      1
`define SW_OPEN      2
`define SW_FAULT     3
`define SW_COAST     4
`define SW_QUICK     5
`define SW_INHIBIT   6
`define SW_WARN      7
`define SW_CTRL      9

// signal numbers
`define SIG_NONE     16'h270f
`define SIG_SPEED_SP 16'h0005
`define SIG_TORQ_SP  16'h0064
`define SIG_SPEED_AV 16'h0006
`define SIG_TORQ_AV  16'h0065
`define SIG_PAR_LO   16'h3000
`define SIG_PAR_HI   16'h35db
`define SIG_MON_LO   16'h4000
`define SIG_MON_HI   16'h4063
`define SIG_CTL_A    16'h5008
`define SIG_CTL_B    16'h5009
`define SIG_CTLX_LO  16'h51f5
`define SIG_CTLX_HI  16'h51fe
`define SIG_CTLX_C   16'h5200

// fault acknowledge hold time
`define ACK_TIME_MS  20
`define CLK_KHZ      100000

`endif

// ===== core/drive_cw_pkg.sv
package drive_cw_pkg;

	typedef enum logic [3:0] {
		ST_INHIBIT = 4'b0001,
		ST_READY   = 4'b0010,
		ST_SWON    = 4'b0100,
		ST_OPEN    = 4'b1000
	} drive_state_t;

endpackage : drive_cw_pkg

// ===== core/drive_control_status_words.sv
`timescale 1ns/1ps
`default_nettype none
`include "drive_cw_map.svh"

// Notes on behaviour
// - duplicate setpoint selectors: lowest wins
// - unknown or none setpoint selector: no write
// - unknown or none actual selector: zero
// - bit1 low shuts output off
// - bit2 low means emergency stop
// - bit5 low holds ramp when running in speed mode with auto restart off
// - bit6 low forces speed setpoint zero
// - bit7 held 20 ms clears faults
// - severe faults survive acknowledge
// - bit10 low: word ignored, only status bit9 follows it
// - bit11 low forces torque zero
// - bit12 inverts direction mapping
// - bit13 starts homing in position control
// - unused status bits return zero
// - status bit0: ready for switching on
// - status bit1: switched on standby
// - status bit2: operation enabled
// - status bit3 and fault record
// - status bits4,5 mirror stop releases
// - status bit6: switching on inhibited
// - status bit7: warning present
// - status bit9: network has control
// - enable needs drive enabled condition
// - fault, mode loss, master stop in operation enabled: inhibit
module drive_control_status_words #(
	parameter int N_SP       = 10,
	parameter int N_ACT      = 14,
	parameter int ACK_CYCLES = `ACK_TIME_MS * `CLK_KHZ
) (
	input  wire logic                  core_clk,
	input  wire logic                  rst,
	input  wire logic                  cw_valid,
	input  wire logic [15:0]           drive_control_word,
	input  wire logic [15:0]           speed_setpoint_word,
	input  wire logic [15:0]           target_torque,
	input  wire logic [N_SP*16-1:0]    setpoint_slot_selectors,
	input  wire logic [N_SP*32-1:0]    sp_slot_data,
	input  wire logic [N_ACT*16-1:0]   actual_slot_selectors,
	input  wire logic [N_ACT*32-1:0]   act_src_data,
	input  wire logic                  net_mode,
	input  wire logic                  master_stop,
	input  wire logic                  drive_enabled,
	input  wire logic                  position_mode,
	input  wire logic                  auto_restart,
	input  wire logic                  fault_active,
	input  wire logic                  fault_severe,
	input  wire logic [15:0]           fault_code,
	input  wire logic                  warning,
	output logic [15:0]                drive_status_word,
	output logic [15:0]                fault_number_record,
	output logic                       fault_reset,
	output logic                       output_shutoff,
	output logic                       emergency_stop,
	output logic                       ramp_hold,
	output logic [15:0]                speed_cmd,
	output logic                       run_fwd,
	output logic                       run_rev,
	output logic [15:0]                torque_cmd,
	output logic                       pos_start,
	output logic [N_SP-1:0]            sp_wr_en,
	output logic [N_SP*32-1:0]         sp_wr_data,
	output logic [N_ACT*32-1:0]        act_slot_data
);

	// ----------------------------------------
	// selector decode
	// ----------------------------------------
	function automatic logic known_sp(input logic [15:0] s);
		known_sp = (s == `SIG_SPEED_SP) || (s == `SIG_TORQ_SP)
			|| (s >= `SIG_PAR_LO && s <= `SIG_PAR_HI)
			|| (s == `SIG_CTL_A) || (s == `SIG_CTL_B);
	endfunction : known_sp

	function automatic logic known_act(input logic [15:0] s);
		known_act = (s == `SIG_SPEED_AV) || (s == `SIG_TORQ_AV)
			|| (s >= `SIG_PAR_LO && s <= `SIG_PAR_HI)
			|| (s >= `SIG_MON_LO && s <= `SIG_MON_HI)
			|| (s == `SIG_CTL_A) || (s == `SIG_CTL_B)
			|| (s >= `SIG_CTLX_LO && s <= `SIG_CTLX_HI)
			|| (s == `SIG_CTLX_C);
	endfunction : known_act

	logic [N_SP-1:0] sp_ok;

	always_comb begin
		sp_ok = '0;
		for (int i = 0; i < N_SP; i++) begin
			sp_ok[i] = known_sp(setpoint_slot_selectors[i*16 +: 16]);
			for (int j = 0; j < i; j++) begin
				if (setpoint_slot_selectors[j*16 +: 16] == setpoint_slot_selectors[i*16 +: 16])
					sp_ok[i] = 1'b0;
			end
		end
	end

	// ----------------------------------------
	// setpoint slot writes
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sp_wr_en   <= '0;
			sp_wr_data <= '0;
		end else begin
			sp_wr_en <= cw_valid ? sp_ok : '0;
			if (cw_valid)
				sp_wr_data <= sp_slot_data;
		end
	end

	// ----------------------------------------
	// actual value slots
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < N_ACT; g++) begin : g_act
			always_ff @(posedge core_clk) begin
				if (rst)
					act_slot_data[g*32 +: 32] <= '0;
				else if (known_act(actual_slot_selectors[g*16 +: 16]))
					act_slot_data[g*32 +: 32] <= act_src_data[g*32 +: 32];
				else
					act_slot_data[g*32 +: 32] <= '0;
			end
		end
	endgenerate

	// ----------------------------------------
	// control word capture
	// ----------------------------------------
	logic [15:0] cw_r;
	logic        ctrl_r;
	logic [15:0] speed_r;
	logic [15:0] torque_r;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			cw_r     <= '0;
			ctrl_r   <= 1'b0;
			speed_r  <= '0;
			torque_r <= '0;
		end else if (cw_valid) begin
			ctrl_r <= drive_control_word[`CW_PLC];
			// word taken only with bit10 set
			if (drive_control_word[`CW_PLC]) begin
				cw_r     <= drive_control_word;
				speed_r  <= speed_setpoint_word;
				torque_r <= target_torque;
			end
		end
	end

	// ----------------------------------------
	// drive state machine
	// ----------------------------------------
	drive_cw_pkg::drive_state_t state_r;
	drive_cw_pkg::drive_state_t state_nxt;
	logic                       force_inhibit;
	logic                       stop_req;

	assign stop_req = !cw_r[`CW_COAST] || !cw_r[`CW_QUICK];
	assign force_inhibit = fault_active || !net_mode
		|| (master_stop && state_r == drive_cw_pkg::ST_OPEN);

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			drive_cw_pkg::ST_INHIBIT: begin
				if (!stop_req && !cw_r[`CW_ON])
					state_nxt = drive_cw_pkg::ST_READY;
			end
			drive_cw_pkg::ST_READY: begin
				if (stop_req)
					state_nxt = drive_cw_pkg::ST_INHIBIT;
				else if (cw_r[`CW_ON])
					state_nxt = drive_cw_pkg::ST_SWON;
			end
			drive_cw_pkg::ST_SWON: begin
				if (stop_req)
					state_nxt = drive_cw_pkg::ST_INHIBIT;
				else if (!cw_r[`CW_ON])
					state_nxt = drive_cw_pkg::ST_READY;
				else if (cw_r[`CW_ENABLE] && drive_enabled)
					state_nxt = drive_cw_pkg::ST_OPEN;
			end
			drive_cw_pkg::ST_OPEN: begin
				if (stop_req)
					state_nxt = drive_cw_pkg::ST_INHIBIT;
				else if (!cw_r[`CW_ON])
					state_nxt = drive_cw_pkg::ST_READY;
				else if (!cw_r[`CW_ENABLE])
					state_nxt = drive_cw_pkg::ST_SWON;
			end
			default: state_nxt = drive_cw_pkg::ST_INHIBIT;
		endcase
		if (force_inhibit)
			state_nxt = drive_cw_pkg::ST_INHIBIT;
	end

	always_ff @(posedge core_clk) begin
		if (rst)
			state_r <= drive_cw_pkg::ST_INHIBIT;
		else
			state_r <= state_nxt;
	end

	// ----------------------------------------
	// fault acknowledge
	// ----------------------------------------
	logic [31:0] ack_cnt_r;
	logic        ack_done_r;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			ack_cnt_r   <= '0;
			ack_done_r  <= 1'b0;
			fault_reset <= 1'b0;
		end else begin
			fault_reset <= 1'b0;
			// bit7 must stay set the full time
			if (!cw_r[`CW_ACK]) begin
				ack_cnt_r  <= '0;
				ack_done_r <= 1'b0;
			end else if (!ack_done_r) begin
				if (ack_cnt_r == 32'(ACK_CYCLES - 1)) begin
					ack_done_r  <= 1'b1;
					fault_reset <= !fault_severe;
				end else begin
					ack_cnt_r <= ack_cnt_r + 32'h0000_0001;
				end
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst)
			fault_number_record <= '0;
		// fault code kept in the record
		else if (fault_active)
			fault_number_record <= fault_code;
		else if (fault_reset)
			fault_number_record <= '0;
	end

	// ----------------------------------------
	// drive commands
	// ----------------------------------------
	logic running;
	logic sp_pos;
	logic sp_neg;

	assign running = (state_nxt == drive_cw_pkg::ST_OPEN);
	assign sp_pos  = cw_r[`CW_SETP] && !speed_r[15] && (speed_r != '0);
	assign sp_neg  = cw_r[`CW_SETP] && speed_r[15];

	always_ff @(posedge core_clk) begin
		if (rst) begin
			output_shutoff <= 1'b1;
			emergency_stop <= 1'b1;
			ramp_hold      <= 1'b0;
			speed_cmd      <= '0;
			torque_cmd     <= '0;
			run_fwd        <= 1'b0;
			run_rev        <= 1'b0;
			pos_start      <= 1'b0;
		end else begin
			output_shutoff <= !cw_r[`CW_COAST];
			emergency_stop <= !cw_r[`CW_QUICK];
			// ramp freeze only while running in speed mode
			ramp_hold <= !cw_r[`CW_RAMP] && running && !position_mode && !auto_restart;
			speed_cmd <= cw_r[`CW_SETP] ? speed_r : '0;
			torque_cmd <= cw_r[`CW_TORQUE] ? torque_r : '0;
			run_fwd <= running && !position_mode && (cw_r[`CW_DIR] ? sp_neg : sp_pos);
			run_rev <= running && !position_mode && (cw_r[`CW_DIR] ? sp_pos : sp_neg);
			pos_start <= cw_r[`CW_HOME] && position_mode && running;
		end
	end

	// ----------------------------------------
	// status word
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			drive_status_word <= '0;
		end else begin
			drive_status_word <= '0;
			drive_status_word[`SW_READY] <= (state_nxt == drive_cw_pkg::ST_READY);
			drive_status_word[`SW_SWON] <= (state_nxt == drive_cw_pkg::ST_SWON);
			drive_status_word[`SW_OPEN] <= (state_nxt == drive_cw_pkg::ST_OPEN);
			drive_status_word[`SW_FAULT] <= fault_active;
			drive_status_word[`SW_COAST] <= cw_r[`CW_COAST];
			drive_status_word[`SW_QUICK] <= cw_r[`CW_QUICK];
			drive_status_word[`SW_INHIBIT] <= (state_nxt == drive_cw_pkg::ST_INHIBIT);
			drive_status_word[`SW_WARN] <= warning;
			drive_status_word[`SW_CTRL] <= ctrl_r && net_mode;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_unused_zero: assert property (@(posedge core_clk) disable iff (rst)
		drive_status_word[15:10] == 6'h00 && !drive_status_word[8])
		else $error("unused status bits set");

	a_ignore_word: assert property (@(posedge core_clk) disable iff (rst)
		cw_valid && !drive_control_word[`CW_PLC] |=> $stable(cw_r))
		else $error("word taken without bit10");

	a_coast_shut: assert property (@(posedge core_clk) disable iff (rst)
		cw_valid && drive_control_word[`CW_PLC] && !drive_control_word[`CW_COAST] ##2 1 |-> output_shutoff)
		else $error("no shutoff on coast stop");

	a_force_inh: assert property (@(posedge core_clk) disable iff (rst)
		fault_active |=> drive_status_word[`SW_INHIBIT] && !drive_status_word[`SW_OPEN])
		else $error("fault did not inhibit");

	a_enable_gate: assert property (@(posedge core_clk) disable iff (rst)
		state_r == drive_cw_pkg::ST_SWON && !drive_enabled |=> state_r != drive_cw_pkg::ST_OPEN)
		else $error("enabled without drive enable");

	a_ack_time: assert property (@(posedge core_clk) disable iff (rst)
		$rose(fault_reset) |-> ack_done_r && $past(cw_r[`CW_ACK]) && $past(ack_cnt_r) == 32'(ACK_CYCLES - 1))
		else $error("fault reset without hold");

	a_severe_keep: assert property (@(posedge core_clk) disable iff (rst)
		fault_reset |-> !$past(fault_severe))
		else $error("severe fault cleared");

	a_setp_zero: assert property (@(posedge core_clk) disable iff (rst)
		!cw_r[`CW_SETP] |=> speed_cmd == 16'h0000)
		else $error("setpoint not zeroed");

	a_torq_zero: assert property (@(posedge core_clk) disable iff (rst)
		!cw_r[`CW_TORQUE] |=> torque_cmd == 16'h0000)
		else $error("torque not zeroed");

	a_dir_excl: assert property (@(posedge core_clk) disable iff (rst)
		!(run_fwd && run_rev))
		else $error("both directions");

	a_sp_dup: assert property (@(posedge core_clk) disable iff (rst)
		setpoint_slot_selectors[15:0] == setpoint_slot_selectors[31:16] |-> !sp_ok[1])
		else $error("duplicate selector honoured");

	a_home_gate: assert property (@(posedge core_clk) disable iff (rst)
		pos_start |-> $past(position_mode) && $past(state_nxt == drive_cw_pkg::ST_OPEN))
		else $error("homing outside enabled state");

endmodule : drive_control_status_words

`default_nettype wire

// ===== testbench/net_master.sv
`timescale 1ns/1ps
`default_nettype none
module net_master (
	input  wire logic        core_clk,
	input  wire logic        req,
	input  wire logic [15:0] req_word,
	output logic             cw_valid,
	output logic [15:0]      drive_control_word
);
	// ------
	// telegram
	// ------
	// reserved bits cleared
	always_ff @(posedge core_clk) begin
		cw_valid <= req;
		drive_control_word <= req ? (req_word & 16'h3cef) : ~drive_control_word;
	end
endmodule : net_master
`default_nettype wire

// ===== testbench/tb_drive_control_status_words.sv
`timescale 1ns/1ps
`default_nettype none
`define chk(nm, e, g) begin checked++; if ((e) !== (g)) begin n_mismatch++; \
$display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_drive_control_status_words;
	localparam int ACK = 20;
	logic          core_clk, rst, req, cw_valid, net_mode, master_stop;
	logic          drive_enabled, position_mode, fault_active, fault_severe, warning;
	logic          fault_reset, output_shutoff, emergency_stop, ramp_hold, run_fwd, run_rev;
	logic          pos_start, auto_rs;
	logic [15:0]   req_word, dcw, speed, torque, fault_code, status, frec, speed_cmd, torque_cmd;
	logic [159:0]  sp_sel;
	logic [319:0]  sp_dat, sp_wd;
	logic [223:0]  act_sel;
	logic [447:0]  act_src, act_out, act_exp;
	logic [9:0]    sp_wr_en, wr_seen;
	int            n_mismatch, checked, cyc;
	time           t_take, t_pulse;

	net_master i_net_master (.core_clk(core_clk), .req(req), .req_word(req_word),
		.cw_valid(cw_valid), .drive_control_word(dcw));

	drive_control_status_words #(.ACK_CYCLES(ACK)) i_drive_control_status_words (
		.core_clk(core_clk), .rst(rst), .cw_valid(cw_valid), .drive_control_word(dcw),
		.speed_setpoint_word(speed), .target_torque(torque), .setpoint_slot_selectors(sp_sel),
		.sp_slot_data(sp_dat), .actual_slot_selectors(act_sel), .act_src_data(act_src),
		.net_mode(net_mode), .master_stop(master_stop), .drive_enabled(drive_enabled),
		.position_mode(position_mode), .auto_restart(auto_rs), .fault_active(fault_active),
		.fault_severe(fault_severe), .fault_code(fault_code), .warning(warning),
		.drive_status_word(status), .fault_number_record(frec), .fault_reset(fault_reset),
		.output_shutoff(output_shutoff), .emergency_stop(emergency_stop), .ramp_hold(ramp_hold),
		.speed_cmd(speed_cmd), .run_fwd(run_fwd), .run_rev(run_rev), .torque_cmd(torque_cmd),
		.pos_start(pos_start), .sp_wr_en(sp_wr_en), .sp_wr_data(sp_wd), .act_slot_data(act_out));

	// ------
	// clock and watchdog
	// ------
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		if (fault_reset === 1'b1)
			t_pulse = $time;
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			summarize();
		end
	end

	// ------
	// helpers
	// ------
	task automatic summarize();
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : summarize

	// one telegram; returns on the edge after the design takes it
	task automatic send(input logic [15:0] w);
		req      <= 1'b1;
		req_word <= w;
		@(posedge core_clk);
		req <= 1'b0;
		@(posedge core_clk);
		#1;
		t_take  = $time;
		wr_seen = sp_wr_en;
		@(posedge core_clk);
	endtask : send

	task automatic settle();
		repeat (3) @(posedge core_clk);
	endtask : settle

	task automatic go_open();
		send(16'h0406);
		send(16'h0407);
		send(16'h040f);
		settle();
	endtask : go_open

	// ------
	// scenarios
	// ------
	task automatic t_reset();
		`chk("status", 16'h0040, status)
		`chk("shutoff", 1'b1, output_shutoff)
		`chk("estop", 1'b1, emergency_stop)
	endtask : t_reset

	task automatic t_states();
		send(16'h0406);
		settle();
		`chk("status", 16'h0231, status)
		`chk("shutoff", 1'b0, output_shutoff)
		`chk("estop", 1'b0, emergency_stop)
		send(16'h0407);
		settle();
		`chk("status", 16'h0232, status)
		send(16'h040f);
		settle();
		`chk("status", 16'h0232, status)
		drive_enabled <= 1'b1;
		send(16'h040f);
		settle();
		`chk("status", 16'h0234, status)
	endtask : t_states

	task automatic t_ignore();
		send(16'h0000);
		settle();
		`chk("status", 16'h0034, status)
	endtask : t_ignore

	task automatic t_speed();
		speed  <= 16'h0100;
		torque <= 16'h0032;
		send(16'h1c4f);
		settle();
		`chk("speed", 16'h0100, speed_cmd)
		`chk("torque", 16'h0032, torque_cmd)
		`chk("rev", 2'b01, {run_fwd, run_rev})
		`chk("hold", 1'b1, ramp_hold)
		auto_rs <= 1'b1;
		settle();
		`chk("hold", 1'b0, ramp_hold)
		auto_rs <= 1'b0;
		send(16'h046f);
		settle();
		`chk("torque", 16'h0000, torque_cmd)
		`chk("fwd", 2'b10, {run_fwd, run_rev})
		`chk("hold", 1'b0, ramp_hold)
		send(16'h040f);
		settle();
		`chk("speed", 16'h0000, speed_cmd)
	endtask : t_speed

	task automatic t_pos();
		position_mode <= 1'b1;
		send(16'h240f);
		settle();
		`chk("pos", 1'b1, pos_start)
		send(16'h2407);
		settle();
		`chk("pos", 1'b0, pos_start)
		position_mode <= 1'b0;
	endtask : t_pos

	task automatic t_ack();
		send(16'h040f);
		t_pulse = 0;
		send(16'h048f);
		repeat (30) @(posedge core_clk);
		`chk("ack", 1'b1, (t_pulse - t_take + 1) / 10 inside {[ACK:ACK + 2]})
		fault_severe <= 1'b1;
		send(16'h040f);
		t_pulse = 0;
		send(16'h048f);
		repeat (30) @(posedge core_clk);
		`chk("severe", 1'b1, t_pulse == 0)
		fault_severe <= 1'b0;
	endtask : t_ack

	task automatic t_slots();
		sp_sel          <= {{5{16'h270f}}, 16'h0064, 16'h0007, 16'h270f, 16'h0005, 16'h0005};
		act_sel         <= {{10{16'h270f}}, 16'h4000, 16'h0001, 16'h270f, 16'h0006};
		act_exp          = '0;
		act_exp[31:0]    = 32'ha5a5_0001;
		act_exp[127:96]  = 32'ha5a5_0001;
		sp_dat          <= {10{32'h1234_0004}};
		send(16'h040f);
		`chk("wr_en", 10'h011, wr_seen)
		`chk("wr_data", sp_dat[159:128], sp_wd[159:128])
		settle();
		`chk("act", act_exp, act_out)
	endtask : t_slots

	task automatic t_force();
		master_stop <= 1'b1;
		settle();
		`chk("status", 16'h0270, status)
		master_stop <= 1'b0;
		send(16'h0406);
		net_mode <= 1'b0;
		settle();
		`chk("status", 16'h0070, status)
		net_mode <= 1'b1;
		send(16'h0406);
		fault_active <= 1'b1;
		fault_code   <= 16'h0010;
		warning      <= 1'b1;
		settle();
		`chk("status", 16'h02f8, status)
		`chk("record", 16'h0010, frec)
		send(16'h0400);
		settle();
		`chk("status", 16'h02c8, status)
		`chk("shutoff", 1'b1, output_shutoff)
		`chk("estop", 1'b1, emergency_stop)
	endtask : t_force

	// ------
	// main sequence
	// ------
	initial begin
		{rst, req, net_mode} = 3'b101;
		{master_stop, drive_enabled, position_mode, fault_active, fault_severe, warning, auto_rs} = '0;
		{req_word, speed, torque, fault_code} = '0;
		sp_sel  = {10{16'h270f}};
		act_sel = {14{16'h270f}};
		sp_dat  = {10{32'h5a5a_0003}};
		act_src = {14{32'ha5a5_0001}};
		{n_mismatch, checked, cyc, t_take, t_pulse} = '0;
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		repeat (3) @(posedge core_clk);
		t_reset();
		t_states();
		t_ignore();
		t_speed();
		t_pos();
		t_ack();
		t_slots();
		t_force();
		summarize();
	end
endmodule : tb_drive_control_status_words
`default_nettype wire
